// ==== hdl/scc_synth_ctrl.sv ====
// Synthesizer channel selection, calibration sequencing and lock events
// Operation
// - Mode 0x4 selects external reference, 0xf internal oscillator on.
// - Four-bit load trim, all codes valid, reset zero.
// - Jitter module forced off while transmitting or filter tuning.
// - Band zero takes frequency from channel field, 0x00 to 0x0a.
// - Bands 1,2,3,6 give base plus 100 kHz per number.
// - Bands 4,5 give base plus 1 MHz per number, limited; 7 reserved.
// - Enable from idle calibrates, settles 170 us, then lock event.
// - Channel change in ready or listen completes within 11 us.
// - Receive frequency 1 MHz lower; steps 16/32 us raise no event.
// - Both calibrations start on enable and on every frequency change while enabled; a running one is not restarted, its countdown continues.
// - Manual centre calibration steps every 8 us, 8 to 264 us.
// - Delay-cell start runs a 10 us calibration, other bits stored and read back.
// - Calibration is never blocked in receive or transmit states.
// - Both calibrations may run concurrently.
// - Lock event clears pending unlock and unlock clears pending lock.
// - Lock after enable, frequency change, manual calibration, or relock.
// - Unlock on manual calibration start or frequency change in ready.
// - Lost lock aborts transmit; reception resumes listening after relock.
// - Return from transmit to ready raises no lock event.
// - Channel field reads back current channel, reset 0x05.
// - Start bits read one while running, cleared when calibration ends.
`timescale 1ns/1ns
module scc_synth_ctrl
  import scc_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         clk_en,
  input  wire scc_reg_req_s reg_req,
  output logic [7:0]        reg_rdata,
  input  wire scc_radio_s   radio,
  input  wire logic         tx_start,
  input  wire logic         tx_end,
  input  wire logic         pll_lock_in,
  input  wire logic         cf_cmp_high,
  input  wire logic         cf_cmp_done,
  input  wire logic         jitter_module_enable,
  input  wire logic         irq_ack_lock,
  input  wire logic         irq_ack_unlock,
  output logic [13:0]       synth_freq,
  output logic              tx_freq_mode,
  output logic [3:0]        osc_mode_field,
  output logic [3:0]        osc_load_trim,
  output logic              osc_ext_ref,
  output logic              osc_int_on,
  output logic              jitter_on,
  output logic              cf_cal_run,
  output logic              dc_cal_run,
  output logic [6:0]        cf_value,
  output logic              irq_lock,
  output logic              irq_unlock,
  output logic              tx_go,
  output logic              tx_abort,
  output logic              rx_resume
);

  // ****************************************
  // Frequency decode
  // ****************************************
  function automatic logic [14:0] freq_calc(input logic [2:0] band,
                                            input logic [4:0] chan,
                                            input logic [7:0] num);
    logic [14:0] res;
    res = '0;
    case (band)
      3'd0: begin
        if (chan == 5'h00) begin
          res = {1'b1, F_EU};
        end else if (chan <= CHAN_MAX) begin
          res = {1'b1, F_NA_BASE + 14'(chan - 5'd1) * F_NA_STEP};
        end
      end
      3'd1: res = {1'b1, F_B1_BASE + 14'(num)};
      3'd2: res = {1'b1, F_B2_BASE + 14'(num)};
      3'd3: res = {1'b1, F_B3_BASE + 14'(num)};
      3'd4: begin
        if (num <= B4_NUM_MAX) begin
          res = {1'b1, F_B4_BASE + 14'(num) * F_COARSE};
        end
      end
      3'd5: begin
        if (num <= B5_NUM_MAX) begin
          res = {1'b1, F_B5_BASE + 14'(num) * F_COARSE};
        end
      end
      3'd6: res = {1'b1, F_B6_BASE + 14'(num)};
      default: res = '0;
    endcase
    return res;
  endfunction

  // ****************************************
  // State
  // ****************************************
  scc_state_e  st_r,       st_nxt;
  logic [14:0] cnt_r,      cnt_nxt;
  logic [4:0]  chan_r,     chan_nxt;
  logic [7:0]  xosc_r,     xosc_nxt;
  logic [7:0]  ccnum_r,    ccnum_nxt;
  logic [2:0]  band_r,     band_nxt;
  logic [6:0]  cfval_r,    cfval_nxt;
  logic [6:0]  dclow_r,    dclow_nxt;
  logic [13:0] freq_r,     freq_nxt;
  logic        cf_run_r,   cf_run_nxt;
  logic        cf_man_r,   cf_man_nxt;
  logic [9:0]  cf_cnt_r,   cf_cnt_nxt;
  logic [5:0]  cf_steps_r, cf_steps_nxt;
  logic        dc_run_r,   dc_run_nxt;
  logic [10:0] dc_cnt_r,   dc_cnt_nxt;
  logic        txup_r,     txup_nxt;
  logic [11:0] txs_cnt_r,  txs_cnt_nxt;
  logic        lost_r,     lost_nxt;
  logic        lockd_r,    lockd_nxt;
  logic        lockp_r,    lockp_nxt;
  logic        unlkp_r,    unlkp_nxt;
  logic [7:0]  rdata_r,    rdata_nxt;
  logic [13:0] sfreq_r,    sfreq_nxt;
  logic        jit_r,      jit_nxt;
  logic        go_r,       go_nxt;
  logic        abort_r,    abort_nxt;
  logic        resume_r,   resume_nxt;
  logic        lock_ev;
  logic        unlock_ev;
  logic        fwr;
  logic [14:0] fcand;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_nxt       = st_r;
    cnt_nxt      = cnt_r;
    chan_nxt     = chan_r;
    xosc_nxt     = xosc_r;
    ccnum_nxt    = ccnum_r;
    band_nxt     = band_r;
    cfval_nxt    = cfval_r;
    dclow_nxt    = dclow_r;
    freq_nxt     = freq_r;
    cf_run_nxt   = cf_run_r;
    cf_man_nxt   = cf_man_r;
    cf_cnt_nxt   = cf_cnt_r;
    cf_steps_nxt = cf_steps_r;
    dc_run_nxt   = dc_run_r;
    dc_cnt_nxt   = dc_cnt_r;
    txup_nxt     = txup_r;
    txs_cnt_nxt  = txs_cnt_r;
    lost_nxt     = lost_r;
    lockd_nxt    = pll_lock_in;
    rdata_nxt    = rdata_r;
    go_nxt       = 1'b0;
    abort_nxt    = 1'b0;
    resume_nxt   = 1'b0;
    lock_ev      = 1'b0;
    unlock_ev    = 1'b0;
    fwr          = 1'b0;
    fcand        = '0;

    // Register writes
    if (reg_req.wr) begin
      case (reg_req.addr)
        ADDR_CHAN: begin
          chan_nxt = reg_req.wdata[4:0];
          fwr      = 1'b1;
        end
        ADDR_XOSC:  xosc_nxt = reg_req.wdata;
        ADDR_CCNUM: begin
          ccnum_nxt = reg_req.wdata;
          fwr       = 1'b1;
        end
        ADDR_BAND: begin
          band_nxt = reg_req.wdata[2:0];
          fwr      = 1'b1;
        end
        ADDR_CFCAL: begin
          if (reg_req.wdata[START_BIT]) begin
            cf_run_nxt   = 1'b1;
            cf_man_nxt   = 1'b1;
            cf_cnt_nxt   = 10'(CF_STEP_CYC);
            cf_steps_nxt = '0;
            if (radio.ready_listen && st_r != ST_OFF) begin
              unlock_ev = 1'b1;
            end
          end
        end
        ADDR_DCCAL: begin
          dclow_nxt = reg_req.wdata[6:0];
          if (reg_req.wdata[START_BIT]) begin
            dc_run_nxt = 1'b1;
            dc_cnt_nxt = 11'(DCU_CYC);
          end
        end
        default: ;
      endcase
    end

    // Frequency selection
    fcand = freq_calc(band_nxt, chan_nxt, ccnum_nxt);
    if (fwr && fcand[14] && fcand[13:0] != freq_r) begin
      freq_nxt = fcand[13:0];
      if (st_r != ST_OFF) begin
        cf_run_nxt   = 1'b1;
        cf_man_nxt   = 1'b0;
        cf_cnt_nxt   = 10'(CF_STEP_CYC);
        cf_steps_nxt = '0;
        dc_run_nxt   = 1'b1;
        dc_cnt_nxt   = 11'(DCU_CYC);
        st_nxt       = ST_SWITCH;
        cnt_nxt      = 15'(SWITCH_CYC);
        if (radio.ready_listen) begin
          unlock_ev = 1'b1;
        end
      end
    end

    // Synthesizer sequence
    case (st_r)
      ST_OFF: begin
        if (radio.pll_on) begin
          st_nxt       = ST_SETTLE;
          cnt_nxt      = 15'(SETTLE_CYCLES);
          cf_run_nxt   = 1'b1;
          cf_man_nxt   = 1'b0;
          cf_cnt_nxt   = 10'(CF_STEP_CYC);
          cf_steps_nxt = '0;
          dc_run_nxt   = 1'b1;
          dc_cnt_nxt   = 11'(DCU_CYC);
        end
      end
      ST_SETTLE, ST_SWITCH: begin
        if (st_nxt == st_r) begin
          if (cnt_r <= 15'd1) begin
            st_nxt  = ST_LOCKED;
            lock_ev = 1'b1;
          end else begin
            cnt_nxt = cnt_r - 15'd1;
          end
        end
      end
      ST_LOCKED: begin
        if (txs_cnt_r == '0 && !cf_run_r && !dc_run_r) begin
          if (lockd_r && !pll_lock_in && !lost_r) begin
            unlock_ev = 1'b1;
            lost_nxt  = 1'b1;
            abort_nxt = radio.tx_busy;
          end
        end
        if (lost_r && pll_lock_in && !lockd_r) begin
          lock_ev    = 1'b1;
          lost_nxt   = 1'b0;
          resume_nxt = radio.rx_busy;
        end
      end
      default: st_nxt = ST_OFF;
    endcase
    if (!radio.pll_on) begin
      st_nxt      = ST_OFF;
      lost_nxt    = 1'b0;
      txup_nxt    = 1'b0;
      txs_cnt_nxt = '0;
    end

    // Transmit frequency step, no lock-loss events during it
    if (radio.pll_on && st_r == ST_LOCKED) begin
      if (tx_start && !txup_r) begin
        txup_nxt    = 1'b1;
        txs_cnt_nxt = 12'(TX_UP_CYC);
      end else if (tx_end && txup_r) begin
        txup_nxt    = 1'b0;
        txs_cnt_nxt = 12'(RX_BACK_CYC);
      end else if (txs_cnt_r != '0) begin
        txs_cnt_nxt = txs_cnt_r - 12'd1;
        go_nxt      = txup_r && txs_cnt_r == 12'd1;
      end
    end

    // Centre-frequency calibration
    if (cf_run_r && !(reg_req.wr && reg_req.addr == ADDR_CFCAL)) begin
      if (cf_cnt_r <= 10'd1) begin
        cf_cnt_nxt = 10'(CF_STEP_CYC);
        if (cf_cmp_done || cf_steps_r >= 6'(CF_MAX_STEPS - 1)) begin
          cf_run_nxt = 1'b0;
          cf_man_nxt = 1'b0;
          if (cf_man_r) begin
            lock_ev = 1'b1;
          end
        end else begin
          cf_steps_nxt = cf_steps_r + 6'd1;
          cfval_nxt    = cf_cmp_high ? cfval_r - 7'd1 : cfval_r + 7'd1;
        end
      end else begin
        cf_cnt_nxt = cf_cnt_r - 10'd1;
      end
    end

    // Delay-cell calibration
    if (dc_run_r && !(reg_req.wr && reg_req.addr == ADDR_DCCAL)) begin
      if (dc_cnt_r <= 11'd1) begin
        dc_run_nxt = 1'b0;
      end else begin
        dc_cnt_nxt = dc_cnt_r - 11'd1;
      end
    end

    // Pending events, set wins over acknowledge
    lockp_nxt = lock_ev | (lockp_r & ~irq_ack_lock & ~unlock_ev);
    unlkp_nxt = (unlock_ev & ~lock_ev) |
                (unlkp_r & ~irq_ack_unlock & ~lock_ev);

    // Derived outputs
    sfreq_nxt = txup_nxt ? freq_nxt : freq_nxt - F_RX_OFFSET;
    jit_nxt = jitter_module_enable & ~radio.tx_busy & ~radio.ftn_run;

    // Register reads
    if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_CHAN:  rdata_nxt = {3'h0, chan_r};
        ADDR_XOSC:  rdata_nxt = xosc_r;
        ADDR_CCNUM: rdata_nxt = ccnum_r;
        ADDR_BAND:  rdata_nxt = {5'h00, band_r};
        ADDR_CFCAL: rdata_nxt = {cf_run_r, cfval_r};
        ADDR_DCCAL: rdata_nxt = {dc_run_r, dclow_r};
        default:    rdata_nxt = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r       <= ST_OFF;
      cnt_r      <= '0;
      chan_r     <= CHAN_RST;
      xosc_r     <= XOSC_RST;
      ccnum_r    <= CCNUM_RST;
      band_r     <= BAND_RST;
      cfval_r    <= CF_VAL_RST;
      dclow_r    <= DC_LOW_RST;
      freq_r     <= F_NA_BASE + 14'(CHAN_RST - 5'd1) * F_NA_STEP;
      cf_run_r   <= 1'b0;
      cf_man_r   <= 1'b0;
      cf_cnt_r   <= '0;
      cf_steps_r <= '0;
      dc_run_r   <= 1'b0;
      dc_cnt_r   <= '0;
      txup_r     <= 1'b0;
      txs_cnt_r  <= '0;
      lost_r     <= 1'b0;
      lockd_r    <= 1'b0;
      lockp_r    <= 1'b0;
      unlkp_r    <= 1'b0;
      rdata_r    <= 8'h00;
      sfreq_r    <= F_NA_BASE + 14'(CHAN_RST - 5'd1) * F_NA_STEP - F_RX_OFFSET;
      jit_r      <= 1'b0;
      go_r       <= 1'b0;
      abort_r    <= 1'b0;
      resume_r   <= 1'b0;
    end else if (clk_en) begin
      st_r       <= st_nxt;
      cnt_r      <= cnt_nxt;
      chan_r     <= chan_nxt;
      xosc_r     <= xosc_nxt;
      ccnum_r    <= ccnum_nxt;
      band_r     <= band_nxt;
      cfval_r    <= cfval_nxt;
      dclow_r    <= dclow_nxt;
      freq_r     <= freq_nxt;
      cf_run_r   <= cf_run_nxt;
      cf_man_r   <= cf_man_nxt;
      cf_cnt_r   <= cf_cnt_nxt;
      cf_steps_r <= cf_steps_nxt;
      dc_run_r   <= dc_run_nxt;
      dc_cnt_r   <= dc_cnt_nxt;
      txup_r     <= txup_nxt;
      txs_cnt_r  <= txs_cnt_nxt;
      lost_r     <= lost_nxt;
      lockd_r    <= lockd_nxt;
      lockp_r    <= lockp_nxt;
      unlkp_r    <= unlkp_nxt;
      rdata_r    <= rdata_nxt;
      sfreq_r    <= sfreq_nxt;
      jit_r      <= jit_nxt;
      go_r       <= go_nxt;
      abort_r    <= abort_nxt;
      resume_r   <= resume_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata      = rdata_r;
  assign synth_freq     = sfreq_r;
  assign tx_freq_mode   = txup_r;
  assign osc_mode_field = xosc_r[OSC_MODE_LSB +: 4];
  assign osc_load_trim  = xosc_r[3:0];
  assign osc_ext_ref    = xosc_r[OSC_MODE_LSB +: 4] == OSC_MODE_EXT;
  assign osc_int_on     = xosc_r[OSC_MODE_LSB +: 4] == OSC_MODE_INT;
  assign jitter_on      = jit_r;
  assign cf_cal_run     = cf_run_r;
  assign dc_cal_run     = dc_run_r;
  assign cf_value       = cfval_r;
  assign irq_lock       = lockp_r;
  assign irq_unlock     = unlkp_r;
  assign tx_go          = go_r;
  assign tx_abort       = abort_r;
  assign rx_resume      = resume_r;

endmodule

// ==== hdl/scc_pkg.sv ====
// Constants and types for the synthesizer channel and calibration control
package scc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CHAN  = 8'h08;
  localparam logic [7:0] ADDR_XOSC  = 8'h12;
  localparam logic [7:0] ADDR_CCNUM = 8'h13;
  localparam logic [7:0] ADDR_BAND  = 8'h14;
  localparam logic [7:0] ADDR_CFCAL = 8'h1a;
  localparam logic [7:0] ADDR_DCCAL = 8'h1b;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int         START_BIT    = 7;
  localparam int         OSC_MODE_LSB = 4;
  localparam logic [4:0] CHAN_RST     = 5'h05;
  localparam logic [7:0] XOSC_RST     = 8'hf0;
  localparam logic [7:0] CCNUM_RST    = 8'h00;
  localparam logic [2:0] BAND_RST     = 3'h0;
  localparam logic [6:0] CF_VAL_RST   = 7'h00;
  localparam logic [6:0] DC_LOW_RST   = 7'h40;
  localparam logic [3:0] OSC_MODE_EXT = 4'h4;
  localparam logic [3:0] OSC_MODE_INT = 4'hf;

  // ****************************************
  // Frequency plan, units of 100 kHz
  // ****************************************
  localparam logic [13:0] F_EU        = 14'd8683;
  localparam logic [13:0] F_NA_BASE   = 14'd9060;
  localparam logic [13:0] F_NA_STEP   = 14'd20;
  localparam logic [13:0] F_B1_BASE   = 14'd7690;
  localparam logic [13:0] F_B2_BASE   = 14'd8570;
  localparam logic [13:0] F_B3_BASE   = 14'd9030;
  localparam logic [13:0] F_B4_BASE   = 14'd7690;
  localparam logic [13:0] F_B5_BASE   = 14'd8330;
  localparam logic [13:0] F_B6_BASE   = 14'd9020;
  localparam logic [13:0] F_COARSE    = 14'd10;
  localparam logic [13:0] F_RX_OFFSET = 14'd10;
  localparam logic [4:0]  CHAN_MAX    = 5'h0a;
  localparam logic [7:0]  B4_NUM_MAX  = 8'h5e;
  localparam logic [7:0]  B5_NUM_MAX  = 8'h66;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_MHZ      = 125;
  localparam int T_SETTLE_US  = 170;
  localparam int T_SWITCH_US  = 11;
  localparam int T_TX_UP_US   = 16;
  localparam int T_RX_BACK_US = 32;
  localparam int T_CF_STEP_US = 8;
  localparam int T_CF_MAX_US  = 270;
  localparam int T_DCU_US     = 10;
  localparam int SETTLE_CYC   = T_SETTLE_US * CLK_MHZ;
  localparam int SWITCH_CYC   = T_SWITCH_US * CLK_MHZ;
  localparam int TX_UP_CYC    = T_TX_UP_US * CLK_MHZ;
  localparam int RX_BACK_CYC  = T_RX_BACK_US * CLK_MHZ;
  localparam int CF_STEP_CYC  = T_CF_STEP_US * CLK_MHZ;
  localparam int DCU_CYC      = T_DCU_US * CLK_MHZ;
  localparam int CF_MAX_STEPS = T_CF_MAX_US / T_CF_STEP_US;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_SETTLE = 2'b01,
    ST_LOCKED = 2'b10,
    ST_SWITCH = 2'b11
  } scc_state_e;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scc_reg_req_s;

  typedef struct packed {
    logic pll_on;
    logic ready_listen;
    logic tx_busy;
    logic rx_busy;
    logic ftn_run;
  } scc_radio_s;

endpackage

// ==== verification/scc_synth_ctrl_monitor.sv ====
// Assertion checker for synthesizer control
`timescale 1ns/1ns
module scc_synth_ctrl_monitor
  import scc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst,
  input wire scc_radio_s radio,
  input wire logic       pll_lock_in,
  input wire logic [3:0] osc_mode_field,
  input wire logic       osc_ext_ref,
  input wire logic       osc_int_on,
  input wire logic       jitter_on,
  input wire logic       dc_cal_run,
  input wire logic       irq_lock,
  input wire logic       irq_unlock,
  input wire logic       tx_freq_mode,
  input wire logic       tx_go,
  input wire logic       tx_abort
);
  // ********************
  // Run-length counters
  // ********************
  logic [11:0] txc_r, txc_nxt;
  logic [11:0] dcc_r, dcc_nxt;
  always_comb begin
    txc_nxt = tx_freq_mode ? txc_r + 12'h001 : 12'h000;
    dcc_nxt = dc_cal_run ? dcc_r + 12'h001 : 12'h000;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txc_r <= 12'h000;
      dcc_r <= 12'h000;
    end else begin
      txc_r <= txc_nxt;
      dcc_r <= dcc_nxt;
    end
  end
  // ********************
  // Properties
  // ********************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_tx_step;
    $rose(tx_freq_mode);
  endsequence
  sequence s_tx_back;
    $fell(tx_freq_mode);
  endsequence
  property p_osc_dec;
    osc_ext_ref == (osc_mode_field == OSC_MODE_EXT) &&
    osc_int_on == (osc_mode_field == OSC_MODE_INT);
  endproperty
  property p_jit_off;
    radio.tx_busy || radio.ftn_run |=> !jitter_on;
  endproperty
  property p_lock_clr;
    $rose(irq_lock) |-> !irq_unlock;
  endproperty
  property p_unl_clr;
    $rose(irq_unlock) |-> !irq_lock;
  endproperty
  property p_tx_quiet;
    s_tx_step |-> (!$rose(irq_lock) && !$rose(irq_unlock)) [*8];
  endproperty
  property p_tx_go;
    tx_go |-> txc_r inside {[12'd1995:12'd2002]};
  endproperty
  property p_tx_back;
    s_tx_back |-> (!$rose(irq_lock)) [*8];
  endproperty
  property p_abort;
    tx_abort |-> $past(radio.tx_busy) && !$past(pll_lock_in);
  endproperty
  property p_dcu;
    $fell(dc_cal_run) |-> dcc_r inside {[12'd1249:12'd1251]};
  endproperty
  a_osc_dec: assert property (p_osc_dec)
    else $error("oscillator mode decode wrong");
  a_jit_off: assert property (p_jit_off)
    else $error("jitter module not forced off");
  a_lock_clr: assert property (p_lock_clr)
    else $error("lock event left unlock pending");
  a_unl_clr: assert property (p_unl_clr)
    else $error("unlock event left lock pending");
  a_tx_quiet: assert property (p_tx_quiet)
    else $error("event during transmit frequency step");
  a_tx_go: assert property (p_tx_go)
    else $error("transmit frequency step time wrong");
  a_tx_back: assert property (p_tx_back)
    else $error("lock event on return from transmit");
  a_abort: assert property (p_abort)
    else $error("transmit abort without lock loss");
  a_dcu: assert property (p_dcu)
    else $error("delay cell calibration length wrong");
endmodule

bind scc_synth_ctrl scc_synth_ctrl_monitor u_mon (
  .clk, .rst, .radio, .pll_lock_in, .osc_mode_field, .osc_ext_ref,
  .osc_int_on, .jitter_on, .dc_cal_run, .irq_lock, .irq_unlock,
  .tx_freq_mode, .tx_go, .tx_abort
);

// ==== verification/scc_pll_model.sv ====
// Loop model: lock comparator and centre calibration compare
`timescale 1ns/1ns
module scc_pll_model #(
  parameter int CONV_CYC = 3000
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic cf_cal_run,
  input  wire logic dc_cal_run,
  input  wire logic break_lock,
  output logic      pll_lock_in,
  output logic      cf_cmp_high,
  output logic      cf_cmp_done
);
  int cf_cyc;
  // Lock is lost while any loop calibrates or when the bench breaks it
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cf_cyc <= 0;
      pll_lock_in <= 1'b0;
      cf_cmp_high <= 1'b0;
      cf_cmp_done <= 1'b0;
    end else begin
      cf_cyc <= cf_cal_run ? cf_cyc + 1 : 0;
      pll_lock_in <= !cf_cal_run && !dc_cal_run && !break_lock;
      cf_cmp_high <= cf_cyc[9];
      cf_cmp_done <= cf_cal_run && (cf_cyc >= CONV_CYC);
    end
  end
endmodule

// ==== verification/scc_synth_ctrl_tb.sv ====
// Testbench for the synthesizer control block
`timescale 1ns/1ns
module scc_synth_ctrl_tb
  import scc_pkg::*;
;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         clk_en = 1'b1;
  scc_reg_req_s rq = '0;
  scc_radio_s   rad = '0;
  logic         tx_start = 1'b0;
  logic         tx_end = 1'b0;
  logic         ack_l = 1'b0;
  logic         ack_u = 1'b0;
  logic         brk = 1'b0;
  logic         jen = 1'b1;
  logic         lock_in;
  logic         cmp_hi;
  logic         cmp_done;
  logic [7:0]   rdata;
  logic [13:0]  freq;
  logic [6:0]   cfv;
  logic [3:0]   mode;
  logic [3:0]   trim;
  logic         ext_ref;
  logic         int_on;
  logic         jit;
  logic         cf_run;
  logic         dc_run;
  logic         irq_l;
  logic         irq_u;
  logic         txm;
  logic         go;
  logic         abort;
  logic         resume;
  int           err_total = 0;
  int           n_checks = 0;
  int           cyc = 0;

  always #4 clk = ~clk;

  scc_synth_ctrl #(.SETTLE_CYCLES(50)) dut (
    .clk(clk), .rst(rst), .clk_en(clk_en), .reg_req(rq),
    .reg_rdata(rdata), .radio(rad), .tx_start(tx_start),
    .tx_end(tx_end), .pll_lock_in(lock_in), .cf_cmp_high(cmp_hi),
    .cf_cmp_done(cmp_done), .jitter_module_enable(jen),
    .irq_ack_lock(ack_l), .irq_ack_unlock(ack_u), .synth_freq(freq),
    .tx_freq_mode(txm), .osc_mode_field(mode), .osc_load_trim(trim),
    .osc_ext_ref(ext_ref), .osc_int_on(int_on), .jitter_on(jit),
    .cf_cal_run(cf_run), .dc_cal_run(dc_run), .cf_value(cfv),
    .irq_lock(irq_l), .irq_unlock(irq_u), .tx_go(go),
    .tx_abort(abort), .rx_resume(resume)
  );
  scc_pll_model u_pll (
    .clk(clk), .rst(rst), .cf_cal_run(cf_run), .dc_cal_run(dc_run),
    .break_lock(brk), .pll_lock_in(lock_in), .cf_cmp_high(cmp_hi),
    .cf_cmp_done(cmp_done)
  );

  // ********************
  // Common tasks
  // ********************
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    rq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    rq.wr <= 1'b0;
    @(negedge clk);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    rq.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask
  function automatic logic pick(input int w);
    case (w)
      0: return irq_l;
      1: return go;
      2: return abort;
      3: return resume;
      default: return !dc_run;
    endcase
  endfunction
  task waitc(input int w, input int lim, output int n);
    n = 0;
    while (pick(w) !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(16'(pick(w)), 16'h0001);
  endtask
  function automatic logic [15:0] fx(input int b, input int n);
    int f;
    case (b)
      0: f = (n == 0) ? 8683 : 9060 + 20 * (n - 1);
      1: f = 7690 + n;
      2: f = 8570 + n;
      3: f = 9030 + n;
      4: f = 7690 + 10 * n;
      5: f = 8330 + 10 * n;
      default: f = 9020 + n;
    endcase
    return 16'(f - 10);
  endfunction
  task pulse_ack;
    @(posedge clk);
    ack_l <= 1'b1;
    ack_u <= 1'b1;
    @(posedge clk);
    ack_l <= 1'b0;
    ack_u <= 1'b0;
  endtask

  // ********************
  // Scenarios
  // ********************
  task t_reset;
    logic [7:0] d;
    logic [7:0] a [6] = '{ADDR_CHAN, ADDR_XOSC, ADDR_CCNUM, ADDR_BAND,
                          ADDR_DCCAL, 8'h30};
    logic [7:0] e [6] = '{8'h05, 8'hf0, 8'h00, 8'h00, 8'h40, 8'h00};
    chk(16'(freq), fx(0, 5));
    for (int i = 0; i < 6; i++) begin
      rd(a[i], d);
      chk(16'(d), 16'(e[i]));
    end
    @(posedge clk);
    clk_en <= 1'b0;
    wr(ADDR_CHAN, 8'h01);
    clk_en <= 1'b1;
    chk(16'(freq), fx(0, 5));
    $display("t_reset done");
  endtask
  task t_osc;
    logic [7:0] d;
    logic [7:0] v;
    for (int t = 0; t < 16; t++) begin
      v = {(t[0] ? 4'h4 : 4'hf), 4'(t)};
      wr(ADDR_XOSC, v);
      chk(16'({ext_ref,int_on,mode,trim}), 16'({t[0],!t[0],v}));
      rd(ADDR_XOSC, d);
      chk(16'(d), 16'(v));
    end
    wr(ADDR_XOSC, 8'h30);
    chk(16'({ext_ref, int_on}), 16'h0000);
    wr(ADDR_XOSC, 8'hf0);
    $display("t_osc done");
  endtask
  task t_freq;
    logic [7:0] d;
    for (int k = 0; k < 11; k++) begin
      wr(ADDR_CHAN, 8'(k));
      chk(16'(freq), fx(0, k));
      rd(ADDR_CHAN, d);
      chk(16'(d), 16'(k));
    end
    wr(ADDR_CHAN, 8'h0b);
    chk(16'(freq), fx(0, 10));
    wr(ADDR_CCNUM, 8'h5e);
    for (int b = 1; b < 7; b++) begin
      wr(ADDR_BAND, 8'(b));
      chk(16'(freq), fx(b, 94));
    end
    wr(ADDR_BAND, 8'h04);
    wr(ADDR_CCNUM, 8'h5f);
    chk(16'(freq), fx(4, 94));
    wr(ADDR_BAND, 8'hff);
    chk(16'(freq), fx(4, 94));
    rd(ADDR_BAND, d);
    chk(16'(d), 16'h0007);
    wr(ADDR_BAND, 8'h00);
    wr(ADDR_CHAN, 8'h05);
    chk(16'(freq), fx(0, 5));
    $display("t_freq done");
  endtask
  task t_lock;
    int n;
    @(posedge clk);
    rad.pll_on <= 1'b1;
    rad.ready_listen <= 1'b1;
    waitc(0, 40000, n);
    chk(16'(irq_u), 16'h0000);
    waitc(4, 3000, n);
    pulse_ack();
    wr(ADDR_CHAN, 8'h06);
    chk(16'({irq_u, irq_l, cf_run, dc_run}), 16'h000b);
    waitc(0, 1400, n);
    chk(16'({irq_u, freq}), fx(0, 6));
    waitc(4, 3000, n);
    $display("t_lock done");
  endtask
  task t_cal;
    logic [7:0] d;
    int n;
    rd(ADDR_CFCAL, d);
    wr(ADDR_CFCAL, d | 8'h80);
    wr(ADDR_DCCAL, 8'h80);
    chk(16'({cf_run, dc_run, irq_u}), 16'h0007);
    rd(ADDR_DCCAL, d);
    chk(16'(d[7]), 16'h0001);
    waitc(0, 34000, n);
    chk(16'(n >= 990), 16'h0001);
    rd(ADDR_CFCAL, d);
    chk(16'(d), 16'({1'b0, cfv}));
    waitc(4, 3000, n);
    rd(ADDR_DCCAL, d);
    chk(16'(d[7]), 16'h0000);
    $display("t_cal done");
  endtask
  task tx_up;
    int n;
    @(posedge clk);
    rad.tx_busy <= 1'b1;
    tx_start <= 1'b1;
    jen <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    @(negedge clk);
    chk(16'({txm, jit}), 16'h0002);
    chk(16'(freq), fx(0, 6) + 16'd10);
    waitc(1, 2100, n);
  endtask
  task t_tx;
    int n;
    pulse_ack();
    @(negedge clk);
    chk(16'({jit, irq_l}), 16'h0002);
    @(posedge clk);
    rad.ftn_run <= 1'b1;
    @(posedge clk);
    rad.ftn_run <= 1'b0;
    jen <= 1'b0;
    @(negedge clk);
    chk(16'(jit), 16'h0000);
    @(negedge clk);
    chk(16'(jit), 16'h0000);
    tx_up();
    @(posedge clk);
    tx_end <= 1'b1;
    rad.tx_busy <= 1'b0;
    @(posedge clk);
    tx_end <= 1'b0;
    repeat (20) @(negedge clk);
    chk(16'({irq_l, txm, freq}), fx(0, 6));
    tx_up();
    @(posedge clk);
    brk <= 1'b1;
    waitc(2, 20, n);
    repeat (20) @(posedge clk);
    brk <= 1'b0;
    rad.tx_busy <= 1'b0;
    rad.rx_busy <= 1'b1;
    repeat (20) @(posedge clk);
    brk <= 1'b1;
    repeat (20) @(posedge clk);
    brk <= 1'b0;
    waitc(3, 200, n);
    $display("t_tx done");
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_osc();
    t_freq();
    t_lock();
    t_cal();
    t_tx();
    final_report();
  end
endmodule
